// ---- verilog/bpdl_map.vh ----
// register offsets, reset values and field positions of the two port block
`ifndef BPDL_MAP_VH
`define BPDL_MAP_VH

`define BPDL_ADDR_W          4
`define BPDL_OFF_PIN_D       4'h0
`define BPDL_OFF_LATCH_D     4'h1
`define BPDL_OFF_DIR_D       4'h2
`define BPDL_OFF_PIN_F       4'h3
`define BPDL_OFF_LATCH_F     4'h4
`define BPDL_OFF_DIR_F       4'h5
`define BPDL_OFF_MODE        4'h6
`define BPDL_OFF_ROUTE_F     4'h7

`define BPDL_RST_DIR         8'hff
`define BPDL_RST_LATCH       8'h00
`define BPDL_RST_MODE        8'h80
`define BPDL_RST_ROUTE_F     8'h00

// writable bits of the mode and routing registers
`define BPDL_MODE_MASK       8'h90
`define BPDL_ROUTE_MASK      8'ha6

// mode register fields
`define BPDL_MODE_EXT_BUS_DIS 7
`define BPDL_MODE_PSP_EN      4
// port f routing register fields
`define BPDL_ROUTE_CMP2       1
`define BPDL_ROUTE_CMP1       2
`define BPDL_ROUTE_COMPARATOR_REFERENCE_OUT      5
`define BPDL_ROUTE_SS         7

`endif

// ---- verilog/bpdl_port_bit.v ----
// one pin of a general purpose port: driver select and input sync
`timescale 1ns/100ps
`default_nettype none

module bpdl_port_bit (
    // clock and reset
    input  wire clk_sys,
    input  wire rst_b,
    // port controls
    input  wire dir_in,
    input  wire latch_val,
    input  wire alt_en,
    input  wire alt_oe,
    input  wire alt_val,
    // pin
    input  wire pin_i,
    output wire pin_o,
    output wire pin_oe,
    output wire pin_sync
);

    reg meta_r;
    reg sync_r;

    // alternate function overrides latch and direction bit; alt_oe gates driver
    assign pin_o  = alt_en ? alt_val : latch_val;
    assign pin_oe = alt_en ? alt_oe : ~dir_in;

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
        end
    end

    assign pin_sync = sync_r;

endmodule

`default_nettype wire

// ---- verilog/bpdl_ports.v ----
// two 8-bit bidirectional ports with direction and output latches
// Notes on behaviour
// R1: direction bit 1 tristates the pin
// R2: direction bit 0 drives latch value
// R3: latch register readable; rmw uses latch
// R4: 8 bits, per-pin direction, schmitt inputs
// R5: power-on reset makes every pin input
// R6: port d is gpio only when bus disabled
// R7: bus active: port d carries address/data low
// R8: parallel slave mode; inputs become ttl
// R9: port f bit 7 gpio or slave select
// R10: software sets bit 7 input for slave select
// R11: port f bits 1,2 drive comparator outputs
// R12: port f bit 5 outputs comparator reference
// R13: direction bit overrides shared peripheral function
// R14: port read gives synced pins; write sets latch
`timescale 1ns/100ps
`default_nettype none
`include "bpdl_map.vh"

module bpdl_ports #(
    parameter WIDTH = 8
) (
    // clock and reset
    input  wire                    clk_sys,
    input  wire                    rst_b,
    // register port
    input  wire [`BPDL_ADDR_W-1:0] reg_addr,
    input  wire [7:0]              reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [7:0]              reg_rdata,
    // external bus low byte
    input  wire [WIDTH-1:0]        ebus_out,
    input  wire                    ebus_oe,
    output wire [WIDTH-1:0]        ebus_in,
    // parallel slave port
    input  wire [WIDTH-1:0]        psp_out,
    input  wire                    psp_oe,
    output wire [WIDTH-1:0]        psp_in,
    output wire                    psp_ttl,
    // peripheral functions on port f
    input  wire                    comparator1_result,
    input  wire                    comparator2_result,
    input  wire                    comparator_reference_out,
    output wire                    slave_select_in,
    output wire                    slave_select_ttl,
    // port d pins
    input  wire [WIDTH-1:0]        pd_i,
    output wire [WIDTH-1:0]        pd_o,
    output wire [WIDTH-1:0]        pd_oe,
    // port f pins
    input  wire [WIDTH-1:0]        pf_i,
    output wire [WIDTH-1:0]        pf_o,
    output wire [WIDTH-1:0]        pf_oe
);

    // ==========================================================
    // registers
    reg  [WIDTH-1:0] direction_d_r;
    reg  [WIDTH-1:0] output_latch_d_r;
    reg  [WIDTH-1:0] direction_f_r;
    reg  [WIDTH-1:0] output_latch_f_r;
    reg  [7:0]       mode_r;
    reg  [7:0]       route_f_r;
    wire [WIDTH-1:0] sync_d;
    wire [WIDTH-1:0] sync_f;
    wire             ext_bus_disable;
    wire             parallel_slave_enable;
    wire             bus_owns_d;
    wire             psp_owns_d;

    assign ext_bus_disable       = mode_r[`BPDL_MODE_EXT_BUS_DIS];
    assign parallel_slave_enable = mode_r[`BPDL_MODE_PSP_EN];
    assign bus_owns_d            = ~ext_bus_disable;                     // [R6]
    assign psp_owns_d            = ext_bus_disable & parallel_slave_enable;

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            direction_d_r    <= `BPDL_RST_DIR;                            // [R5]
            direction_f_r    <= `BPDL_RST_DIR;                            // [R5]
            output_latch_d_r <= `BPDL_RST_LATCH;
            output_latch_f_r <= `BPDL_RST_LATCH;
            mode_r           <= `BPDL_RST_MODE;
            route_f_r        <= `BPDL_RST_ROUTE_F;
        end else if (reg_wr) begin
            case (reg_addr)
                // writing either the pin or latch register updates the latch
                `BPDL_OFF_PIN_D:   output_latch_d_r <= reg_wdata;         // [R14]
                `BPDL_OFF_LATCH_D: output_latch_d_r <= reg_wdata;         // [R3]
                `BPDL_OFF_DIR_D:   direction_d_r    <= reg_wdata;         // [R4]
                `BPDL_OFF_PIN_F:   output_latch_f_r <= reg_wdata;         // [R14]
                `BPDL_OFF_LATCH_F: output_latch_f_r <= reg_wdata;         // [R3]
                `BPDL_OFF_DIR_F:   direction_f_r    <= reg_wdata;         // [R4]
                `BPDL_OFF_MODE:    mode_r           <= reg_wdata & `BPDL_MODE_MASK;
                `BPDL_OFF_ROUTE_F: route_f_r        <= reg_wdata & `BPDL_ROUTE_MASK;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // read data, one cycle after the strobe; zero otherwise
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `BPDL_OFF_PIN_D:   reg_rdata <= sync_d;                   // [R14]
                `BPDL_OFF_LATCH_D: reg_rdata <= output_latch_d_r;         // [R3]
                `BPDL_OFF_DIR_D:   reg_rdata <= direction_d_r;
                `BPDL_OFF_PIN_F:   reg_rdata <= sync_f;                   // [R14]
                `BPDL_OFF_LATCH_F: reg_rdata <= output_latch_f_r;         // [R3]
                `BPDL_OFF_DIR_F:   reg_rdata <= direction_f_r;
                `BPDL_OFF_MODE:    reg_rdata <= mode_r;
                `BPDL_OFF_ROUTE_F: reg_rdata <= route_f_r;
                default:           reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // per-pin logic
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
            wire f_alt_en;
            wire f_alt_val;
            // shared outputs follow direction bit, so software can override
            assign f_alt_en  = (i == `BPDL_ROUTE_CMP1 || i == `BPDL_ROUTE_CMP2 ||
                                i == `BPDL_ROUTE_COMPARATOR_REFERENCE_OUT) ? route_f_r[i] : 1'b0;
            assign f_alt_val = (i == `BPDL_ROUTE_CMP2)  ? comparator2_result :  // [R11]
                               (i == `BPDL_ROUTE_CMP1)  ? comparator1_result :  // [R11]
                               comparator_reference_out;                      // [R12]

            bpdl_port_bit u_d (
                .clk_sys   (clk_sys),
                .rst_b     (rst_b),
                .dir_in    (direction_d_r[i]),                            // [R1] [R2]
                .latch_val (output_latch_d_r[i]),                         // [R2]
                .alt_en    (bus_owns_d | psp_owns_d),                     // [R6] [R8]
                .alt_oe    (bus_owns_d ? ebus_oe : psp_oe),               // [R7]
                .alt_val   (bus_owns_d ? ebus_out[i] : psp_out[i]),       // [R7] [R8]
                .pin_i     (pd_i[i]),
                .pin_o     (pd_o[i]),
                .pin_oe    (pd_oe[i]),
                .pin_sync  (sync_d[i])
            );

            bpdl_port_bit u_f (
                .clk_sys   (clk_sys),
                .rst_b     (rst_b),
                .dir_in    (direction_f_r[i]),                            // [R1] [R2]
                .latch_val (output_latch_f_r[i]),
                .alt_en    (f_alt_en),
                .alt_oe    (~direction_f_r[i]),                           // [R13]
                .alt_val   (f_alt_val),
                .pin_i     (pf_i[i]),
                .pin_o     (pf_o[i]),
                .pin_oe    (pf_oe[i]),
                .pin_sync  (sync_f[i])
            );
        end
    endgenerate

    // ==========================================================
    // peripheral inputs
    assign ebus_in          = sync_d;                                     // [R7]
    assign psp_in           = sync_d;
    assign psp_ttl          = psp_owns_d;                                 // [R8]
    assign slave_select_in  = sync_f[`BPDL_ROUTE_SS];                     // [R9]
    assign slave_select_ttl = route_f_r[`BPDL_ROUTE_SS];                  // [R9]

endmodule

`default_nettype wire

// ---- dv/bpdl_chk.sv ----
// checker for the port block: register timing and pin ownership
`timescale 1ns/100ps
`default_nettype none
`include "bpdl_map.vh"
module bpdl_chk (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_b,
    // register port
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // pins and side functions
    input wire logic [7:0] ebus_out,
    input wire logic       ebus_oe,
    input wire logic [7:0] pd_o,
    input wire logic [7:0] pd_oe,
    input wire logic [7:0] pf_i,
    input wire logic [7:0] pf_o,
    input wire logic [7:0] pf_oe,
    input wire logic       psp_ttl,
    input wire logic       slave_select_in,
    input wire logic       slave_select_ttl
);
    // ========
    // write qualifiers
    wire logic wdf = reg_wr && reg_addr == `BPDL_OFF_DIR_F;
    wire logic wlf = reg_wr && reg_addr == `BPDL_OFF_LATCH_F;
    wire logic wmd = reg_wr && reg_addr == `BPDL_OFF_MODE;
    wire logic wrt = reg_wr && reg_addr == `BPDL_OFF_ROUTE_F;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    rd_quiet_a:
        assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
    unmapped_a:
        assert property ($past(reg_rd && reg_addr > 4'h7) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    reset_in_a:
        assert property ($rose(rst_b) |-> pf_oe == 8'h00 && pd_oe == 8'h00)
        else $error("pins driven after reset");
    dir_oe_a:
        assert property ($past(wdf) |-> pf_oe == ~$past(reg_wdata)) else $error("oe vs dir");
    latch_out_a:
        assert property ($past(wlf) |-> (pf_o & pf_oe & 8'h59) == ($past(reg_wdata) & pf_oe & 8'h59))
        else $error("pin not latch");
    bus_own_a:
        assert property ($past(wmd && !reg_wdata[7]) |-> pd_oe == {8{ebus_oe}} && pd_o == ebus_out)
        else $error("bus not on port d");
    psp_ttl_a:
        assert property ($past(wmd) |-> psp_ttl == ($past(reg_wdata[7]) && $past(reg_wdata[4])))
        else $error("ttl select wrong");
    ss_ttl_a:
        assert property ($past(wrt) |-> slave_select_ttl == $past(reg_wdata[7]))
        else $error("select ttl wrong");
    ss_sync_a:
        assert property ($past(rst_b, 2) && $past(rst_b) |-> slave_select_in == $past(pf_i[7], 2))
        else $error("select sync wrong");
endmodule
bind bpdl_ports bpdl_chk chk_u (.*);
`default_nettype wire

// ---- dv/bpdl_pins.sv ----
// pins and board devices on one port: resolves drive, undriven bits float
`timescale 1ns/100ps
`default_nettype none
module bpdl_pins (
    // clock
    input  wire logic       clk_sys,
    // pin drive from the port
    input  wire logic [7:0] drv_o,
    input  wire logic [7:0] drv_oe,
    // board devices
    input  wire logic [7:0] ext_v,
    input  wire logic [7:0] ext_en,
    // resolved level
    output logic      [7:0] lvl
);
    logic [7:0] flt_r = 8'h55;
    // no pull on these pins, a floating bit toggles each cycle
    always @(posedge clk_sys) flt_r <= ~flt_r;
    assign lvl = (drv_oe & drv_o) | (~drv_oe & ext_en & ext_v) | (~drv_oe & ~ext_en & flt_r);
endmodule
`default_nettype wire

// ---- dv/tb_bidir_port_direction_latch.sv ----
// testbench for the two port block
`timescale 1ns/100ps
`default_nettype none
`include "bpdl_map.vh"
module tb_bidir_port_direction_latch;
    logic       clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, ebus_oe = 0, psp_oe = 0, rd_d = 0;
    logic       comparator1_result = 0, comparator2_result = 0, comparator_reference_out = 0;
    logic       psp_ttl, slave_select_in, slave_select_ttl;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, ebus_out = 0, psp_out = 0, dv = 0, de = 0, fv = 0, fe = 0;
    logic [7:0] reg_rdata, ebus_in, psp_in, pd_i, pd_o, pd_oe, pf_i, pf_o, pf_oe, v, lf = 8'h3b;
    logic [7:0] expq[$];
    int         errors = 0, n_checks = 0, cyc = 0;
    bpdl_ports dut_u (.*);
    bpdl_pins  pd_u (.clk_sys, .drv_o(pd_o), .drv_oe(pd_oe), .ext_v(dv), .ext_en(de), .lvl(pd_i));
    bpdl_pins  pf_u (.clk_sys, .drv_o(pf_o), .drv_oe(pf_oe), .ext_v(fv), .ext_en(fe), .lvl(pf_i));
    initial forever #2 clk_sys = ~clk_sys;
    // ========
    // helpers
    function logic [7:0] nx(input logic [7:0] s);
        nx = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one bus cycle; a read notes its expected data
    task bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        if (r) expq.push_back(d);
        @(posedge clk_sys);
    endtask
    task idle;
        bus(0, 0, 4'h0, 8'h00);
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        if (rd_d) chk(reg_rdata, expq.pop_front());
        rd_d <= reg_rd;
        cyc++;
        if (cyc > 2000) begin
            errors++;
            report_and_stop;
        end
    end
    // ========
    // tests
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_b <= 1;
        @(posedge clk_sys);
        bus(0, 1, `BPDL_OFF_DIR_D, 8'hff);
        bus(0, 1, `BPDL_OFF_DIR_F, 8'hff);
        bus(0, 1, `BPDL_OFF_LATCH_F, 8'h00);
        bus(0, 1, `BPDL_OFF_MODE, 8'h80);
        bus(0, 1, 4'hc, 8'h00);
        idle;
        chk(pf_oe | pd_oe, 8'h00);
        $display("reset test done");
        repeat (4) begin
            lf = nx(lf);
            v = nx(lf);
            bus(1, 0, `BPDL_OFF_DIR_F, lf);
            bus(1, 0, `BPDL_OFF_LATCH_F, v);
            bus(1, 0, `BPDL_OFF_DIR_D, ~lf);
            bus(1, 0, `BPDL_OFF_LATCH_D, v);
            bus(0, 1, `BPDL_OFF_DIR_F, lf);
            bus(0, 1, `BPDL_OFF_LATCH_D, v);
            idle;
            chk(pf_oe, ~lf);
            chk(pf_o & ~lf, v & ~lf);
            chk(pd_oe, lf);
            chk(pd_o & lf, v & lf);
        end
        $display("direction test done");
        bus(1, 0, `BPDL_OFF_DIR_F, 8'hff);
        bus(1, 0, `BPDL_OFF_LATCH_F, 8'h5a);
        fv <= 8'ha5;
        fe <= 8'hff;
        repeat (3) idle;
        bus(0, 1, `BPDL_OFF_PIN_F, 8'ha5);
        bus(0, 1, `BPDL_OFF_LATCH_F, 8'h5a);
        bus(1, 0, `BPDL_OFF_PIN_F, 8'h3c);
        bus(0, 1, `BPDL_OFF_LATCH_F, 8'h3c);
        idle;
        $display("latch test done");
        fe <= 8'h80;
        fv <= 8'h00;
        comparator2_result <= 1;
        bus(1, 0, `BPDL_OFF_DIR_F, 8'h80);
        bus(1, 0, `BPDL_OFF_ROUTE_F, 8'hff);
        bus(0, 1, `BPDL_OFF_ROUTE_F, 8'ha6);
        idle;
        // latch holds 3c here, so a routed bit that fell back to it would show
        chk(pf_o & 8'h26, 8'h02);
        chk({6'h0, slave_select_ttl, slave_select_in}, 8'h02);
        comparator1_result <= 1;
        comparator2_result <= 0;
        comparator_reference_out <= 1;
        bus(1, 0, `BPDL_OFF_LATCH_F, 8'h02);
        idle;
        chk(pf_o & 8'h26, 8'h24);
        bus(1, 0, `BPDL_OFF_DIR_F, 8'ha6);
        idle;
        chk(pf_oe, 8'h59);
        $display("routing test done");
        ebus_out <= 8'hc3;
        ebus_oe <= 1;
        psp_out <= 8'h3c;
        psp_oe <= 1;
        bus(1, 0, `BPDL_OFF_MODE, 8'h00);
        idle;
        chk(pd_oe, 8'hff);
        chk(pd_o, 8'hc3);
        bus(1, 0, `BPDL_OFF_MODE, 8'h90);
        idle;
        chk(pd_o & pd_oe, 8'h3c);
        chk({7'h0, psp_ttl}, 8'h01);
        psp_oe <= 0;
        de <= 8'hff;
        dv <= 8'h96;
        repeat (3) idle;
        chk(psp_in, 8'h96);
        chk(ebus_in, 8'h96);
        bus(0, 1, `BPDL_OFF_PIN_D, 8'h96);
        // let the read answer be compared before the verdict
        repeat (2) idle;
        $display("mode test done");
        report_and_stop;
    end
endmodule
`default_nettype wire
